// *** rtl/page_map_pkg.sv ***
// Constants for the program paging and data-space layout block
package page_map_pkg;
    // Data-space register offsets
    localparam logic [7:0] PAGE_SEL_ADDR = 8'hca;
    localparam logic [7:0] BANK_SEL_ADDR = 8'hcb;
    localparam logic [7:0] WIN_PTR_ADDR = 8'hc9;
    // Data-space regions
    localparam logic [7:0] BANK_LO = 8'h00;
    localparam logic [7:0] BANK_HI = 8'h3f;
    localparam logic [7:0] WIN_LO = 8'h40;
    localparam logic [7:0] WIN_HI = 8'h7f;
    localparam logic [7:0] RAM_LO = 8'h84;
    localparam logic [7:0] RAM_HI = 8'hbf;
    // Program-space layout
    localparam int PC_W = 12;
    localparam int PHYS_W = 13;
    localparam int PAGE_BIT = 11;
    localparam logic [1:0] STATIC_PAGE = 2'h1;
    localparam logic [11:0] IRQ_VEC_LO = 12'hff0;
    localparam logic [11:0] IRQ_VEC_HI = 12'hff7;
    localparam logic [11:0] NMI_VEC = 12'hffc;
    localparam logic [11:0] RST_VEC = 12'hffe;
    // Stack and bank sizing
    localparam int STACK_DEPTH = 6;
    localparam int BANK_BYTES = 64;
    localparam int GEN_RAM_BYTES = 60;
    localparam int BANK_COUNT = 4;
    // Reset values of the pointer registers
    localparam logic [7:0] WIN_PTR_RST = 8'h00;
    localparam logic [1:0] BANK_SEL_RST = 2'h0;
    localparam logic [2:0] SP_RST = 3'h0;
endpackage

// *** rtl/return_stack.sv ***
// Six-level hardware return address stack
`timescale 1ns/100ps
`default_nettype none
module return_stack (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Push and pop requests
    input wire logic push,
    input wire logic pop,
    input wire logic [11:0] push_addr,
    // Top of stack and depth
    output logic [11:0] top_addr,
    output logic [2:0] depth,
    output logic overflow
);
    // Storage for return addresses
    logic [11:0] slot_reg [page_map_pkg::STACK_DEPTH];
    logic [2:0] sp_reg;
    logic [2:0] sp_next;
    logic full;
    logic empty;

    assign full = (sp_reg == 3'(page_map_pkg::STACK_DEPTH));
    assign empty = (sp_reg == 3'h0);
    assign top_addr = empty ? 12'h000 : slot_reg[sp_reg - 3'h1];
    assign depth = sp_reg;
    // Overflow drops the push; deeper nesting is a software fault
    assign overflow = push && full;
    assign sp_next = (push && !full) ? sp_reg + 3'h1 :
                     (pop && !empty) ? sp_reg - 3'h1 : sp_reg;

    // ------------------------------------------------------------
    // Pointer update
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sp_reg <= page_map_pkg::SP_RST;
        end else begin
            sp_reg <= sp_next;
        end
    end

    // Slot write, no reset needed on stored addresses
    always_ff @(posedge ref_clk) begin
        if (push && !full) begin
            slot_reg[sp_reg] <= push_addr;
        end
    end
endmodule
`default_nettype wire

// *** rtl/page_map.sv ***
// Program paging and data-space decode for the 8-bit core
`timescale 1ns/100ps
`default_nettype none
module page_map (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Core program fetch
    input wire logic [11:0] pc,
    output logic [12:0] prog_phys_addr,
    output logic [1:0] page_in_use,
    output logic vector_hit,
    // Core data access
    input wire logic [7:0] data_addr,
    input wire logic data_wr,
    input wire logic data_rd,
    input wire logic bit_op,
    input wire logic [7:0] data_wdata,
    output logic [7:0] data_rdata,
    output logic data_hit,
    // Program memory byte read for the window
    output logic [12:0] win_phys_addr,
    input wire logic [7:0] prog_rdata,
    // Core stack control
    input wire logic call_push,
    input wire logic ret_pop,
    output logic [11:0] return_addr,
    output logic [2:0] stack_depth,
    output logic stack_overflow,
    // External programming read path
    input wire logic readout_protect,
    input wire logic ext_rd,
    input wire logic [12:0] ext_addr,
    output logic [12:0] ext_phys_addr,
    output logic [7:0] ext_rdata,
    output logic ext_blocked
);
    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    // Inclusive range compare used by every region decode
    function automatic logic in_range(input logic [7:0] a,
                                      input logic [7:0] lo,
                                      input logic [7:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    // ------------------------------------------------------------
    // State and storage
    // ------------------------------------------------------------
    // The page register has no reset: it powers up unknown and
    // software owns its first value. The window pointer and bank select,
    // which the core can read back, are cleared so their reads after reset are clean.
    // Page register: only two bits live, no reset value by design
    logic [1:0] page_number_bits_reg;
    // Window pointer in 64-byte steps across program memory
    logic [6:0] constant_window_pointer_reg;
    // Bank select: both bits pick one of the four banks
    logic [1:0] ram_eeprom_bank_select_reg;
    // Storage arrays
    logic [7:0] gen_ram [page_map_pkg::GEN_RAM_BYTES];
    logic [7:0] bank_mem [page_map_pkg::BANK_COUNT * page_map_pkg::BANK_BYTES];
    // Registered read data
    logic [7:0] rdata_reg;
    logic hit_reg;
    logic [7:0] ext_rdata_reg;
    logic blocked_reg;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Each region compare is a plain range check on the byte address.
    // The regions never overlap, so the read mux order is only a
    // matter of style and not of priority.
    // Decode wires
    wire logic page_wr;
    wire logic win_ptr_wr;
    wire logic bank_sel_wr;
    wire logic in_bank;
    wire logic in_win;
    wire logic in_ram;
    wire logic [5:0] ram_idx;
    wire logic [7:0] bank_idx;
    wire logic [1:0] fetch_page;

    // Bit operations arrive as writes with bit_op high; the core
    // still raises data_wr for the write-back half of the operation.
    // A bit operation is a read-modify-write, so it may not touch
    // the write-only page register at all
    assign page_wr = data_wr && !bit_op &&
                     (data_addr == page_map_pkg::PAGE_SEL_ADDR);
    assign win_ptr_wr = data_wr &&
                        (data_addr == page_map_pkg::WIN_PTR_ADDR);
    assign bank_sel_wr = data_wr &&
                         (data_addr == page_map_pkg::BANK_SEL_ADDR);
    assign in_bank = in_range(data_addr, page_map_pkg::BANK_LO,
                              page_map_pkg::BANK_HI);
    assign in_win = in_range(data_addr, page_map_pkg::WIN_LO,
                             page_map_pkg::WIN_HI);
    assign in_ram = in_range(data_addr, page_map_pkg::RAM_LO,
                             page_map_pkg::RAM_HI);
    // General RAM starts at 84h, so its index is the offset from there.
    // Banks are indexed by the select bits over the low address bits.
    assign ram_idx = 6'(data_addr - page_map_pkg::RAM_LO);
    assign bank_idx = {ram_eeprom_bank_select_reg, data_addr[5:0]};

    // ------------------------------------------------------------
    // Program fetch mapping
    // ------------------------------------------------------------
    // The physical address is thirteen bits: two page bits on top of
    // the eleven in-page bits of the program counter. Page 1 reached
    // through the lower half and through the upper half is the same
    // physical memory.
    // Upper half always hits the static page, lower half the chosen one
    assign fetch_page = pc[page_map_pkg::PAGE_BIT] ?
                        page_map_pkg::STATIC_PAGE :
                        page_number_bits_reg;
    assign page_in_use = fetch_page;
    assign prog_phys_addr = {fetch_page, pc[10:0]};
    // The flag covers the maskable block and the two-byte NMI and
    // reset words; the reserved gap between them stays low.
    // Vector area flag for the core's vector fetch
    assign vector_hit = ((pc >= page_map_pkg::IRQ_VEC_LO) &&
                         (pc <= page_map_pkg::IRQ_VEC_HI)) ||
                        (pc[11:1] == page_map_pkg::NMI_VEC[11:1]) ||
                        (pc[11:1] == page_map_pkg::RST_VEC[11:1]);

    // Window address: pointer supplies the high bits
    assign win_phys_addr = {constant_window_pointer_reg,
                            data_addr[5:0]};

    // ------------------------------------------------------------
    // Page register; not reset, core pushes never touch it
    // ------------------------------------------------------------
    // Software must load it before any lower-half fetch
    // A lower-half fetch before the first write sees an unknown page,
    // which shows as X on the physical address in simulation.
    // Interrupt entry leaves this register alone, so a handler that
    // changes it must restore it itself from a RAM image.
    always_ff @(posedge ref_clk) begin
        if (page_wr) begin
            page_number_bits_reg <= data_wdata[1:0];
        end
    end

    // ------------------------------------------------------------
    // Window and bank pointers
    // ------------------------------------------------------------
    // Seven pointer bits of 64-byte steps span all of program memory.
    // Bank select keeps two bits; upper bits written are dropped.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            constant_window_pointer_reg <= page_map_pkg::WIN_PTR_RST[6:0];
            ram_eeprom_bank_select_reg <= page_map_pkg::BANK_SEL_RST;
        end else begin
            if (win_ptr_wr) begin
                constant_window_pointer_reg <= data_wdata[6:0];
            end
            if (bank_sel_wr) begin
                ram_eeprom_bank_select_reg <= data_wdata[1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // General RAM and bank storage writes
    // ------------------------------------------------------------
    // Arrays carry no reset: RAM content is undefined at power-up,
    // and clearing it would cost a long reset sequence.
    // Window is read-only, so writes there are dropped
    always_ff @(posedge ref_clk) begin
        if (data_wr && in_ram) begin
            gen_ram[ram_idx] <= data_wdata;
        end
        if (data_wr && in_bank) begin
            bank_mem[bank_idx] <= data_wdata;
        end
    end

    // ------------------------------------------------------------
    // Data read path, one cycle latency
    // ------------------------------------------------------------
    // Read data is registered, so the core samples it one cycle
    // after the request. Between reads the last value stays on the
    // bus while the hit flag drops back low.
    // Page register reads as zero and gives no hit
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata_reg <= 8'h00;
            hit_reg <= 1'b0;
        end else if (data_rd) begin
            hit_reg <= in_bank || in_win || in_ram ||
                       (data_addr == page_map_pkg::WIN_PTR_ADDR) ||
                       (data_addr == page_map_pkg::BANK_SEL_ADDR);
            if (in_bank) begin
                rdata_reg <= bank_mem[bank_idx];
            end else if (in_win) begin
                rdata_reg <= prog_rdata;
            end else if (in_ram) begin
                rdata_reg <= gen_ram[ram_idx];
            end else if (data_addr == page_map_pkg::WIN_PTR_ADDR) begin
                rdata_reg <= {1'b0, constant_window_pointer_reg};
            end else if (data_addr == page_map_pkg::BANK_SEL_ADDR) begin
                rdata_reg <= {6'h00, ram_eeprom_bank_select_reg};
            end else begin
                rdata_reg <= 8'h00;
            end
        end else begin
            hit_reg <= 1'b0;
        end
    end
    assign data_rdata = rdata_reg;
    assign data_hit = hit_reg;

    // ------------------------------------------------------------
    // External readout path, gated by the protection option
    // ------------------------------------------------------------
    // The external path shares the program memory data input with
    // the window, so an external read and a window read in the same
    // cycle return the same byte; the programmer never overlaps them.
    // The blocked flag lets the programmer tell a zero byte from a
    // protected one, since a blank location also reads as zero.
    // Address is passed through; data is zeroed when protected
    assign ext_phys_addr = ext_addr;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ext_rdata_reg <= 8'h00;
            blocked_reg <= 1'b0;
        end else if (ext_rd) begin
            ext_rdata_reg <= readout_protect ? 8'h00 : prog_rdata;
            blocked_reg <= readout_protect;
        end else begin
            blocked_reg <= 1'b0;
        end
    end
    assign ext_rdata = ext_rdata_reg;
    assign ext_blocked = blocked_reg;

    // ------------------------------------------------------------
    // Return stack
    // ------------------------------------------------------------
    // Pushes only the PC; the page selection is never saved
    // The core supplies the return offset itself; a seventh nested
    // call is dropped and flagged, which software must never rely on.
    return_stack u_stack (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .push(call_push),
        .pop(ret_pop),
        .push_addr(pc),
        .top_addr(return_addr),
        .depth(stack_depth),
        .overflow(stack_overflow)
    );
endmodule
`default_nettype wire

// *** tb/page_map_assertions.sv ***
// Concurrent checks on the ports of the paging and data-space block
`timescale 1ns/100ps
`default_nettype none
module page_map_assertions (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Program side
    input wire logic [11:0] pc,
    input wire logic [12:0] prog_phys_addr,
    input wire logic vector_hit,
    // Data side
    input wire logic [7:0] data_addr,
    input wire logic data_wr,
    input wire logic data_rd,
    input wire logic [7:0] data_rdata,
    input wire logic data_hit,
    input wire logic [12:0] win_phys_addr,
    input wire logic [7:0] prog_rdata,
    // Stack
    input wire logic call_push,
    input wire logic [2:0] stack_depth,
    input wire logic stack_overflow,
    // External read path
    input wire logic readout_protect,
    input wire logic ext_rd,
    input wire logic [12:0] ext_addr,
    input wire logic [12:0] ext_phys_addr,
    input wire logic [7:0] ext_rdata,
    input wire logic ext_blocked
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Vector locations in the static page
    wire vec = (pc >= 12'hff0 && pc <= 12'hff7) || pc >= 12'hffc;
    wire win = data_addr >= 8'h40 && data_addr <= 8'h7f;
    a_static_page: assert property (pc[11] |->
        prog_phys_addr[12:11] == 2'h1) else $error("static page missed");
    a_page_offset: assert property (
        prog_phys_addr[10:0] == pc[10:0]) else $error("offset lost");
    a_page_keep: assert property (
        (call_push && !pc[11] && !data_wr) ##1 !pc[11] |->
        $stable(prog_phys_addr[12:11])) else $error("page moved on call");
    a_vector_map: assert property (vector_hit == vec)
        else $error("vector decode wrong");
    a_stack_grow: assert property (
        call_push && stack_depth < 3'h6 |=>
        stack_depth == $past(stack_depth) + 3'h1) else $error("no push");
    a_stack_full: assert property (
        stack_overflow == (call_push && stack_depth == 3'h6))
        else $error("overflow flag wrong");
    a_win_data: assert property (data_rd && win |=>
        data_rdata == $past(prog_rdata)) else $error("window data wrong");
    a_win_addr: assert property (
        win_phys_addr[5:0] == data_addr[5:0]) else $error("window offset");
    a_page_noread: assert property (
        data_rd && data_addr == 8'hca |=> !data_hit)
        else $error("page register readable");
    a_ext_block: assert property (readout_protect && ext_rd |=>
        ext_blocked && ext_rdata == 8'h00) else $error("readout leaked");
    a_ext_addr: assert property (ext_phys_addr == ext_addr)
        else $error("external address wrong");
endmodule
bind page_map page_map_assertions chk (.ref_clk, .rst_n, .pc,
    .prog_phys_addr, .vector_hit, .data_addr, .data_wr, .data_rd,
    .data_rdata, .data_hit, .win_phys_addr, .prog_rdata, .call_push,
    .stack_depth, .stack_overflow, .readout_protect, .ext_rd, .ext_addr,
    .ext_phys_addr, .ext_rdata, .ext_blocked);
`default_nettype wire

// *** tb/prog_mem_model.sv ***
// Program memory model answering window fetches in the same cycle
`timescale 1ns/100ps
`default_nettype none
module prog_mem_model (
    // Fetch address
    input wire logic [12:0] addr,
    // Byte returned
    output logic [7:0] rdata
);
    // Content follows the address so every read can be predicted
    assign rdata = addr[7:0] ^ {3'h0, addr[12:8]};
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the paging and data-space block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic ref_clk, rst_n, data_wr, data_rd, bit_op, call_push, ret_pop;
    logic readout_protect, ext_rd, vector_hit, data_hit;
    logic stack_overflow, ext_blocked;
    logic [11:0] pc, return_addr;
    logic [12:0] prog_phys_addr, win_phys_addr, ext_addr, ext_phys_addr;
    logic [7:0] data_addr, data_wdata, data_rdata, prog_rdata, ext_rdata;
    logic [1:0] page_in_use;
    logic [2:0] stack_depth;
    int failures = 0, compares = 0, i;
    page_map dut (.ref_clk, .rst_n, .pc, .prog_phys_addr, .page_in_use,
        .vector_hit, .data_addr, .data_wr, .data_rd, .bit_op, .data_wdata,
        .data_rdata, .data_hit, .win_phys_addr, .prog_rdata, .call_push,
        .ret_pop, .return_addr, .stack_depth, .stack_overflow,
        .readout_protect, .ext_rd, .ext_addr, .ext_phys_addr, .ext_rdata,
        .ext_blocked);
    prog_mem_model mem (.addr(win_phys_addr), .rdata(prog_rdata));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [12:0] got, input logic [12:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Inputs move 1 ns after the edge
    task automatic cyc;
        @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic b);
        data_addr = a; data_wdata = d; bit_op = b; data_wr = 1'b1;
        cyc;
        data_wr = 1'b0; bit_op = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e,
                      input logic h);
        data_addr = a; data_rd = 1'b1;
        cyc;
        data_rd = 1'b0;
        chk(data_hit, h);
        if (h) chk(data_rdata, e);
    endtask
    task automatic wrap_up;
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Watchdog sized well past the roughly fifty cycles of the tests
    initial begin
        #20000;
        failures++;
        wrap_up;
    end
    initial begin
        {data_wr, data_rd, bit_op, call_push, ret_pop, ext_rd} = '0;
        {readout_protect, rst_n} = '0;
        pc = 12'h000; data_addr = 8'h00; data_wdata = 8'h00;
        ext_addr = 13'h0000;
        repeat (4) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        // Image is written before the page register each time
        for (i = 0; i < 4; i++) begin
            wr(8'h84, 8'hfc | i[7:0], 1'b0);
            wr(8'hca, 8'hfc | i[7:0], 1'b0);
            pc = 12'h123; #1 chk(prog_phys_addr, {i[1:0], 11'h123});
            chk(page_in_use, i[1:0]);
            pc = 12'h923; #1 chk(prog_phys_addr, {2'h1, 11'h123});
        end
        wr(8'hca, 8'h00, 1'b1);
        pc = 12'h123; #1 chk(prog_phys_addr, {2'h3, 11'h123});
        rd(8'hca, 8'h00, 1'b0);
        wr(8'hbf, 8'h5a, 1'b0);
        rd(8'h84, 8'hff, 1'b1);
        rd(8'hbf, 8'h5a, 1'b1);
        $display("test page done");
        for (i = 0; i < 7; i++) begin
            pc = 12'h100 + i[11:0]; call_push = 1'b1;
            #1 chk(stack_overflow, i == 6);
            cyc;
        end
        call_push = 1'b0;
        chk(stack_depth, 3'h6);
        chk(return_addr, 12'h105);
        chk(prog_phys_addr[12:11], 2'h3);
        ret_pop = 1'b1;
        cyc;
        ret_pop = 1'b0;
        chk(return_addr, 12'h104);
        $display("test stack done");
        for (i = 'hfe8; i < 'h1000; i++) begin
            pc = i[11:0];
            #1 chk(vector_hit, (i >= 'hff0 && i <= 'hff7) || i >= 'hffc);
        end
        $display("test vectors done");
        wr(8'hc9, 8'h05, 1'b0);
        rd(8'h45, 8'h44, 1'b1);
        wr(8'h7f, 8'h00, 1'b0);
        rd(8'h7f, 8'h7e, 1'b1);
        for (i = 0; i < 8; i++) begin
            wr(8'hcb, i[7:0] & 8'h03, 1'b0);
            if (i < 4) wr(8'h3f, 8'h30 + i[7:0], 1'b0);
            else rd(8'h3f, 8'h2c + i[7:0], 1'b1);
        end
        $display("test window and banks done");
        ext_addr = 13'h1abc; readout_protect = 1'b1; ext_rd = 1'b1;
        #1 chk(ext_phys_addr, 13'h1abc);
        cyc;
        ext_rd = 1'b0;
        chk(ext_blocked, 1'b1);
        chk(ext_rdata, 8'h00);
        readout_protect = 1'b0; ext_rd = 1'b1;
        cyc;
        ext_rd = 1'b0;
        chk(ext_blocked, 1'b0);
        chk(ext_rdata, 8'h7e);
        $display("test readout done");
        wrap_up;
    end
endmodule
`default_nettype wire
